/* hdl/fbp_top.sv */
/*
  Burst read sequencer, stall timing, write protection and program suspend of
  a synchronous boot-block flash. The array itself is outside; this block drives
  its word address and tells when data is valid. Assumes all inputs synchronous
  to clk.
*/
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Continuous bursts drive stall during the delay or one cycle before it.
// - Continuous bursts always run linear; interleaved applies only to 4 and 8.
// - Interleaved order follows the tabulated group sequence.
// - Clock-edge bit picks rising or falling edge for start, data and stall.
// - Four and eight word bursts output that many words, wrapping in group.
// - Continuous bursts increment linearly until the last burstable address.
// - Boundary delay at first 16-word crossing; four-aligned starts see none.
// - Start on last word of a quad: delay equals the latency code.
// - Boundary delay happens once per burst, never without a crossing.
// - Stall output flags each boundary delay; host ignores data then.
// - Low program supply fails erase or program and sets supply error.
// - Protect low rejects writes to lockable blocks with a status error.
// - Lockable set: main blocks plus 21,22 top-boot or 0,1 bottom-boot.
// - Reset or low supply lock all; else protect decides.
// - Suspend command B0H; engine-ready bit reads 0 while busy.
// - Once ready, suspended bit is 1 if halted, 0 if completed.
// - While suspended, read array allowed; D0H resumes programming.
// - Active while chip enable low and reset high; standby otherwise.
// - After a read, hold last data in low-power state until new read.
// - Stall timing bit: 0 during delay, 1 one cycle before.
// - Order bit: 0 interleaved, 1 linear.
// - Edge bit: 0 falling, 1 rising.
// - Length codes 001 four, 010 eight, 111 continuous.
module fbp_top
  import fbp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic chip_en_n,
  input wire fbp_cfg_t cfg,
  input wire logic burst_start,
  input wire logic [18:0] start_addr,
  input wire logic [15:0] array_data,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic prog_req,
  input wire logic [4:0] prog_block,
  input wire logic supply_ok,
  input wire logic protect_n,
  input wire logic top_boot,
  output logic [18:0] array_addr,
  output logic [15:0] read_data,
  output logic data_valid,
  output logic stall_n,
  output logic active,
  output logic power_save,
  output fbp_status_t status
);

  // ****************************************************************
  // Burst sequencer
  // ****************************************************************

  fbp_burst_state_t state;
  logic [18:0] base;
  logic [2:0] beat;
  logic [2:0] start_off;
  logic [3:0] left;
  logic [2:0] delay_cnt;
  logic delay_done;
  logic edge_q;
  logic is_cont;
  logic is_len8;
  logic is_len4;
  logic [2:0] next_off;
  logic [18:0] next_addr;
  logic [18:0] cont_addr;
  logic at_boundary;
  logic pre_boundary;
  logic in_delay;
  logic go;
  logic fall_phase;
  logic last_line;

  assign is_cont = (cfg.burst_length_field == FBP_BL_CONT);
  assign is_len8 = (cfg.burst_length_field == FBP_BL_8);
  assign is_len4 = (cfg.burst_length_field == FBP_BL_4);

  // Falling-edge mode advances on alternate cycles, modelling the half-period shift.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      edge_q <= 1'b0;
    else
      edge_q <= !edge_q;
  end
  assign fall_phase = cfg.clock_edge_sel || edge_q;

  // Offset of the next beat within the wrap group.
  always_comb
  begin
    next_off = beat + 3'h1;
    if (!cfg.burst_order_sel)
      next_off = start_off ^ (beat + 3'h1);
    else
      next_off = start_off + beat + 3'h1;
    if (is_len4)
      next_addr = {base[18:2], next_off[1:0]};
    else
      next_addr = {base[18:3], next_off};
  end

  assign cont_addr = array_addr + 19'h00001;
  // Crossing into the next 16-word line happens when the low nibble is all ones.
  // The last 16-word line has no line after it, so it never pays a boundary delay.
  assign last_line = (array_addr[18:4] == FBP_ADDR_LAST[18:4]);
  assign at_boundary = is_cont && (array_addr[3:0] == FBP_GROUP16_LAST) && !delay_done &&
                       !last_line;
  assign pre_boundary = is_cont && (array_addr[3:0] == (FBP_GROUP16_LAST - 4'h1)) &&
                        !delay_done && !last_line;
  assign in_delay = (delay_cnt != 3'h0);
  // A deselected chip takes no further beat, so the last word read stays on the outputs.
  assign go = (state == FBP_BURST) && fall_phase && !in_delay && !chip_en_n;

  // Burst state and address generation.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= FBP_IDLE;
      array_addr <= '0;
      base <= '0;
      beat <= '0;
      start_off <= '0;
      left <= '0;
    end
    else if (chip_en_n)
      state <= FBP_IDLE;
    else
    begin
      case (state)
        FBP_IDLE, FBP_HOLD:
        begin
          if (burst_start && fall_phase)
          begin
            array_addr <= start_addr;
            base <= start_addr;
            beat <= '0;
            start_off <= start_addr[2:0];
            if (is_len4)
              left <= 4'h3;
            else if (is_len8)
              left <= 4'h7;
            else
              left <= 4'h0;
            state <= FBP_BURST;
          end
        end
        FBP_BURST:
        begin
          if (go)
          begin
            if (is_cont)
            begin
              if (array_addr == FBP_ADDR_LAST)
                state <= FBP_HOLD;
              else
                array_addr <= cont_addr;
            end
            else if (left == 4'h0)
              state <= FBP_HOLD;
            else
            begin
              array_addr <= next_addr;
              beat <= beat + 3'h1;
              left <= left - 4'h1;
            end
          end
        end
        default: state <= FBP_IDLE;
      endcase
    end
  end

  // Boundary delay: length depends on start offset within its quad.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      delay_cnt <= '0;
      delay_done <= 1'b0;
    end
    else if (state != FBP_BURST)
    begin
      delay_cnt <= '0;
      delay_done <= 1'b0;
    end
    else if (in_delay)
      delay_cnt <= delay_cnt - 3'h1;
    else if (go && at_boundary)
    begin
      delay_done <= 1'b1;
      // Aligned starts incur nothing; last-of-quad starts pay the full latency.
      if (base[1:0] == 2'h0)
        delay_cnt <= 3'h0;
      else if (base[1:0] == 2'h3)
        delay_cnt <= cfg.initial_latency_code;
      else
        delay_cnt <= {1'b0, base[1:0]};
    end
  end

  // Stall output, during the delay or one cycle ahead of it.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      stall_n <= 1'b1;
    else if (!is_cont || state != FBP_BURST || base[1:0] == 2'h0)
      stall_n <= 1'b1;
    else if (cfg.stall_timing_sel)
      stall_n <= !((pre_boundary && go) || (at_boundary && go) ||
                   (delay_cnt > 3'h1));
    else
      stall_n <= !((at_boundary && go) || (delay_cnt > 3'h1));
  end

  // Read data capture and auto power save holding the last word.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      read_data <= '0;
      data_valid <= 1'b0;
      power_save <= 1'b0;
      active <= 1'b0;
    end
    else
    begin
      active <= !chip_en_n;
      data_valid <= go; // The word that opens the delay is still a valid beat.
      if (go)
        read_data <= array_data;
      power_save <= !chip_en_n && (state != FBP_BURST);
    end
  end

  // ****************************************************************
  // Write protection and program engine
  // ****************************************************************

  logic locked;
  logic supply_low;
  fbp_eng_state_t eng;
  logic [7:0] prog_cnt;
  logic req_q;

  fbp_lock u_lock (
    .clk(clk),
    .resetn(resetn),
    .supply_ok(supply_ok),
    .protect_n(protect_n),
    .top_boot(top_boot),
    .block(prog_block),
    .locked(locked),
    .supply_low(supply_low)
  );

  // Request is delayed one cycle to line up with the registered lock decision.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      req_q <= 1'b0;
    else
      req_q <= prog_req && (eng == FBP_ENG_READY);
  end

  // Program engine with suspend and resume.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      eng <= FBP_ENG_READY;
      prog_cnt <= '0;
      status <= '{engine_ready_bit: 1'b1, default: 1'b0};
    end
    else
    begin
      case (eng)
        FBP_ENG_READY:
        begin
          if (cmd_valid && cmd_code == FBP_CMD_SUSPEND)
            status.program_suspended_bit <= 1'b0;
          if (req_q)
          begin
            if (supply_low)
              status.supply_error_bit <= 1'b1;
            else if (locked)
              status.block_lock_error <= 1'b1;
            else
            begin
              eng <= FBP_ENG_BUSY;
              prog_cnt <= FBP_PROG_CYCLES;
              status.engine_ready_bit <= 1'b0;
            end
          end
        end
        FBP_ENG_BUSY:
        begin
          if (cmd_valid && cmd_code == FBP_CMD_SUSPEND)
          begin
            eng <= FBP_ENG_SUSP;
            status.engine_ready_bit <= 1'b1;
            status.program_suspended_bit <= 1'b1;
          end
          else if (prog_cnt == 8'h01)
          begin
            eng <= FBP_ENG_READY;
            status.engine_ready_bit <= 1'b1;
          end
          else
            prog_cnt <= prog_cnt - 8'h01;
        end
        FBP_ENG_SUSP:
        begin
          if (cmd_valid && cmd_code == FBP_CMD_RESUME)
          begin
            eng <= FBP_ENG_BUSY;
            status.engine_ready_bit <= 1'b0;
            status.program_suspended_bit <= 1'b0;
          end
        end
        default: eng <= FBP_ENG_READY;
      endcase
    end
  end

endmodule // fbp_top

`default_nettype wire

/* hdl/fbp_pkg.sv */
/*
  Package of the burst read and protection block: configuration field positions,
  burst length codes, command codes, block map figures and grouped signal types.
  Assumes a single synchronous clock domain at 40 MHz.
*/
package fbp_pkg;

  // Read configuration field positions.
  localparam int FBP_STALL_TIMING_BIT = 8;
  localparam int FBP_BURST_ORDER_BIT = 7;
  localparam int FBP_CLOCK_EDGE_BIT = 6;
  localparam int FBP_LATENCY_LSB = 11;

  // Reset value of the read configuration register.
  localparam logic [15:0] FBP_RCR_RESET = 16'h0000;

  // Burst length codes.
  localparam logic [2:0] FBP_BL_4 = 3'h1;
  localparam logic [2:0] FBP_BL_8 = 3'h2;
  localparam logic [2:0] FBP_BL_CONT = 3'h7;

  // Address space and block map.
  localparam int FBP_ADDR_W = 19;
  localparam logic [18:0] FBP_ADDR_LAST = 19'h7FFFF;
  localparam logic [4:0] FBP_BLK_TOP_LOCK_A = 5'h15;
  localparam logic [4:0] FBP_BLK_TOP_LOCK_B = 5'h16;
  localparam logic [4:0] FBP_BLK_BOT_LOCK_A = 5'h00;
  localparam logic [4:0] FBP_BLK_BOT_LOCK_B = 5'h01;
  localparam logic [4:0] FBP_TOP_PARAM_FIRST = 5'h0F;
  localparam logic [4:0] FBP_BOT_PARAM_LAST = 5'h07;

  // Commands.
  localparam logic [7:0] FBP_CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] FBP_CMD_RESUME = 8'hD0;
  localparam logic [7:0] FBP_CMD_READ_ARRAY = 8'hFF;

  // Length of a program operation in clocks, an arbitrary engine model.
  localparam logic [7:0] FBP_PROG_CYCLES = 8'h20;

  // Stall figures.
  localparam logic [3:0] FBP_GROUP16_LAST = 4'hF;

  typedef struct packed {
    logic stall_timing_sel;
    logic burst_order_sel;
    logic clock_edge_sel;
    logic [2:0] burst_length_field;
    logic [2:0] initial_latency_code;
  } fbp_cfg_t;

  typedef struct packed {
    logic engine_ready_bit;
    logic program_suspended_bit;
    logic supply_error_bit;
    logic block_lock_error;
  } fbp_status_t;

  typedef enum logic [1:0] {FBP_IDLE, FBP_BURST, FBP_HOLD} fbp_burst_state_t;
  typedef enum logic [1:0] {FBP_ENG_READY, FBP_ENG_BUSY, FBP_ENG_SUSP} fbp_eng_state_t;

endpackage

/* hdl/fbp_lock.sv */
/*
  Block lock decoder: tells whether a write aimed at a block may proceed.
  Assumes inputs synchronous to clk; the result is registered.
*/
`timescale 1ns/1ps
`default_nettype none

module fbp_lock
  import fbp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic supply_ok,
  input wire logic protect_n,
  input wire logic top_boot,
  input wire logic [4:0] block,
  output logic locked,
  output logic supply_low
);

  // Tells whether a block is in the lockable set for the boot configuration.
  function automatic logic fbp_lockable(input logic top, input logic [4:0] b);
    if (top)
      fbp_lockable = (b < FBP_TOP_PARAM_FIRST) || (b == FBP_BLK_TOP_LOCK_A) ||
                     (b == FBP_BLK_TOP_LOCK_B);
    else
      fbp_lockable = (b > FBP_BOT_PARAM_LAST) || (b == FBP_BLK_BOT_LOCK_A) ||
                     (b == FBP_BLK_BOT_LOCK_B);
  endfunction

  // Registered lock decision; reset itself locks everything.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      locked <= 1'b1;
      supply_low <= 1'b0;
    end
    else
    begin
      supply_low <= !supply_ok;
      locked <= !supply_ok || (!protect_n && fbp_lockable(top_boot, block));
    end
  end

endmodule // fbp_lock

`default_nettype wire

/* verification/fbp_top_properties.sv */
/*
  Concurrent checks on the ports of the burst read and protection block.
  Assumes one clock domain and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module fbp_top_properties
  import fbp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic chip_en_n,
  input wire fbp_cfg_t cfg,
  input wire logic burst_start,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic prog_req,
  input wire logic [4:0] prog_block,
  input wire logic supply_ok,
  input wire logic protect_n,
  input wire logic top_boot,
  input wire logic [18:0] array_addr,
  input wire logic [15:0] read_data,
  input wire logic data_valid,
  input wire logic stall_n,
  input wire logic active,
  input wire fbp_status_t status
);
  // ****************
  // Helpers
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic lockable;
  logic adv;
  // Lockable set: main blocks plus the two boot-end parameter blocks.
  assign lockable = top_boot ? (prog_block < 5'h0F || prog_block > 5'h14) :
                    (prog_block > 5'h07 || prog_block < 5'h02);
  // Rising-edge mode, where a running burst may step its address on every cycle.
  assign adv = cfg.clock_edge_sel;
  sequence s_halted;
    status.engine_ready_bit && status.program_suspended_bit;
  endsequence
  sequence s_resumed;
    !status.engine_ready_bit && !status.program_suspended_bit;
  endsequence
  // ****************
  // Checks
  // ****************
  standby_follow_a: assert property ($past(resetn) |-> active == !$past(chip_en_n))
    else $error("active does not follow chip enable");
  wrap_four_a: assert property ($changed(array_addr) && !$past(burst_start) && adv &&
    cfg.burst_length_field == FBP_BL_4 |-> array_addr[18:2] == $past(array_addr[18:2]))
    else $error("four word burst left its group");
  wrap_eight_a: assert property ($changed(array_addr) && !$past(burst_start) && adv &&
    cfg.burst_length_field == FBP_BL_8 |-> array_addr[18:3] == $past(array_addr[18:3]))
    else $error("eight word burst left its group");
  cont_linear_a: assert property ($changed(array_addr) && !$past(burst_start) && adv &&
    cfg.burst_length_field == FBP_BL_CONT |-> array_addr == $past(array_addr) + 19'h1)
    else $error("continuous burst not linear");
  no_stall_a: assert property (cfg.burst_length_field != FBP_BL_CONT |-> stall_n)
    else $error("stall outside continuous burst");
  supply_err_a: assert property (prog_req && status.engine_ready_bit && !supply_ok
    |-> ##[1:3] status.supply_error_bit) else $error("supply error not flagged");
  lock_err_a: assert property (prog_req && status.engine_ready_bit && supply_ok &&
    !protect_n && lockable |-> ##[1:3] status.block_lock_error) else $error("lock missed");
  unlock_busy_a: assert property (prog_req && status.engine_ready_bit && supply_ok &&
    (protect_n || !lockable) |-> ##[1:3] !status.engine_ready_bit) else $error("no start");
  suspend_a: assert property (cmd_valid && cmd_code == FBP_CMD_SUSPEND &&
    !status.engine_ready_bit |-> ##[1:3] s_halted) else $error("suspend not reported");
  resume_a: assert property (cmd_valid && cmd_code == FBP_CMD_RESUME &&
    status.program_suspended_bit |-> ##[1:3] s_resumed) else $error("resume failed");
  hold_data_a: assert property ($changed(read_data) |-> data_valid)
    else $error("read data changed without a beat");
endmodule // fbp_top_properties

bind fbp_top fbp_top_properties fbp_top_properties_i (.*);

`default_nettype wire

/* verification/fbp_array_model.sv */
/*
  Array model: returns a word derived from the address at once.
  Assumes the block reads the word in the cycle after the address.
*/
`timescale 1ns/1ps
`default_nettype none

module fbp_array_model (
  input wire logic [18:0] addr,
  output logic [15:0] data
);
  // Each location holds a pattern that differs from its neighbours.
  assign data = addr[15:0] ^ 16'h5A5A;
endmodule // fbp_array_model

`default_nettype wire

/* verification/test_flash_burst_read_and_protect.sv */
/*
  Testbench: burst sequences, stall counts, write protection and suspend.
  Assumes the checker is bound to the top and the array model answers at once.
*/
`timescale 1ns/1ps
`default_nettype none

module test_flash_burst_read_and_protect
  import fbp_pkg::*;
();
  logic clk, resetn, chip_en_n, burst_start, cmd_valid, prog_req, stall_sel;
  logic supply_ok, protect_n, top_boot, data_valid, stall_n, active, power_save;
  fbp_cfg_t cfg;
  fbp_status_t status;
  logic [18:0] start_addr, array_addr;
  logic [15:0] array_data, read_data;
  logic [7:0] cmd_code;
  logic [4:0] prog_block;
  int mismatches;
  int checked;
  fbp_top fbp_top_i (.clk(clk), .resetn(resetn), .chip_en_n(chip_en_n), .cfg(cfg),
    .burst_start(burst_start), .start_addr(start_addr), .array_data(array_data),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .prog_req(prog_req),
    .prog_block(prog_block), .supply_ok(supply_ok), .protect_n(protect_n),
    .top_boot(top_boot), .array_addr(array_addr), .read_data(read_data),
    .data_valid(data_valid), .stall_n(stall_n), .active(active),
    .power_save(power_save), .status(status));
  fbp_array_model fbp_array_model_i (.addr(array_addr), .data(array_data));
  // ****************
  // Tasks
  // ****************
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset;
    resetn = 0;
    repeat (6) @(negedge clk);
    resetn = 1;
  endtask
  // Word address of beat k for the given length and order.
  function automatic logic [18:0] exp_addr(logic [2:0] len, logic lin, logic [18:0] s, int k);
    if (len == FBP_BL_4)
      return {s[18:2], lin ? s[1:0] + 2'(k) : s[1:0] ^ 2'(k)};
    if (len == FBP_BL_8)
      return {s[18:3], lin ? s[2:0] + 3'(k) : s[2:0] ^ 3'(k)};
    return s + 19'(k);
  endfunction
  // Interleaved order is never combined with continuous length.
  task automatic burst(input logic [2:0] len, input logic lin, input logic rise,
      input logic [18:0] s, input int nb, input int stalls, input bit tail);
    int k;
    int st;
    logic [18:0] a;
    k = 0;
    st = 0;
    a = 0;
    cfg = '{stall_sel, lin, rise, len, 3'h3};
    start_addr = s;
    burst_start = 1;
    repeat (rise ? 1 : 2) @(negedge clk);
    burst_start = 0;
    for (int c = 0; c < 80 && k < nb; c++)
    begin
      @(negedge clk);
      st += !stall_n;
      if (data_valid)
      begin
        a = exp_addr(len, lin, s, k);
        check(read_data, a[15:0] ^ 16'h5A5A);
        k++;
      end
    end
    repeat (tail ? 8 : 0) @(negedge clk) k += data_valid;
    check(k, nb);
    check(st, stalls);
    chip_en_n = 1;
    repeat (2) @(negedge clk);
    check({active, power_save}, 0);
    chip_en_n = 0;
    repeat (2) @(negedge clk);
    check({active, power_save, read_data}, {2'h3, a[15:0] ^ 16'h5A5A});
  endtask
  task automatic prog(input logic [4:0] blk, input logic top, input logic prot, input logic sup);
    {prog_block, top_boot, protect_n, supply_ok} = {blk, top, prot, sup};
    prog_req = 1;
    @(negedge clk);
    prog_req = 0;
    repeat (3) @(negedge clk);
  endtask
  task automatic cmd(input logic [7:0] code);
    cmd_code = code;
    cmd_valid = 1;
    @(negedge clk);
    cmd_valid = 0;
    repeat (3) @(negedge clk);
  endtask
  // Polls status until the engine reports ready.
  task automatic wait_ready;
    for (int i = 0; i < 60 && status.engine_ready_bit !== 1'b1; i++) @(negedge clk);
  endtask
  // ****************
  // Tests
  // ****************
  initial
  begin
    #(25 * 6000);
    mismatches++;
    close_out;
  end
  initial
  begin
    {chip_en_n, burst_start, cmd_valid, prog_req, top_boot, stall_sel, resetn} = 0;
    {supply_ok, protect_n, cmd_code, prog_block, start_addr, cfg} = 0;
    {mismatches, checked} = 0;
    @(negedge clk);
    do_reset;
    check({status, stall_n, data_valid}, 6'h22);
    burst(FBP_BL_4, 1, 1, 19'h00101, 4, 0, 1);
    burst(FBP_BL_4, 0, 1, 19'h00203, 4, 0, 1);
    burst(FBP_BL_8, 0, 1, 19'h00301, 8, 0, 1);
    burst(FBP_BL_8, 1, 1, 19'h0040D, 8, 0, 1);
    burst(FBP_BL_8, 0, 1, 19'h00506, 8, 0, 1);
    burst(FBP_BL_4, 1, 0, 19'h00602, 4, 0, 1);
    burst(3'h3, 1, 1, 19'h00705, 1, 0, 1);
    burst(FBP_BL_CONT, 1, 1, 19'h00803, 20, 3, 0);
    burst(FBP_BL_CONT, 1, 1, 19'h00904, 20, 0, 0);
    burst(FBP_BL_CONT, 1, 1, 19'h00A01, 20, 1, 0);
    stall_sel = 1;
    burst(FBP_BL_CONT, 1, 1, 19'h00B01, 20, 2, 0);
    stall_sel = 0;
    burst(FBP_BL_CONT, 1, 1, 19'h7FFFD, 3, 0, 1);
    $display("test bursts done");
    prog(5'h15, 1, 1, 1);
    check(status, 4'h0);
    cmd(FBP_CMD_SUSPEND);
    wait_ready;
    check(status, 4'hC);
    cmd(FBP_CMD_READ_ARRAY);
    burst(FBP_BL_4, 1, 1, 19'h00C00, 4, 0, 1);
    cmd(FBP_CMD_RESUME);
    check(status, 4'h0);
    wait_ready;
    cmd(FBP_CMD_SUSPEND);
    check(status, 4'h8);
    prog(5'h03, 0, 0, 1);
    check(status, 4'h0);
    wait_ready;
    prog(5'h01, 0, 0, 1);
    check(status, 4'h9);
    do_reset;
    prog(5'h03, 0, 1, 0);
    check(status, 4'hA);
    $display("test program done");
    close_out;
  end
endmodule // test_flash_burst_read_and_protect

`default_nettype wire
